// ==== design/tbpd_decoder.sv ====
`default_nettype none
module tbpd_decoder (
  input wire logic CLK_I,
  input wire logic RESETN_I,
  input wire logic CODE_VALID_I,
  input wire logic [6:0] CODE_I,
  output logic READY_O,
  output logic FUNC_START_O,
  output logic POS_START_O,
  output logic ROW_LOCK_O,
  output logic SHIFT_O,
  output logic FIELD_O,
  output logic [1:0] ROW_O,
  output logic [3:0] COL_O,
  output logic POS_VALID_O
);
  tbpd_pkg::tbpd_state_t state;
  tbpd_pkg::tbpd_state_t next_state;
  logic [6:0] code;
  logic [6:0] pending;
  logic pending_full;
  logic field;
  logic common_row;
  logic [1:0] row;
  logic [1:0] col_in_group;
  logic [3:0] col;
  logic [1:0] lock_cnt;
  logic take;
  localparam logic [1:0] LOCK_LAST = tbpd_pkg::LOCK_CYC_W - 2'h1;

  // a character can wait while the previous one is positioned
  assign READY_O = !pending_full;
  assign take = (state == tbpd_pkg::TBPD_IDLE) && pending_full;

  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      pending <= tbpd_pkg::CODE_RST;
      pending_full <= 1'b0;
    end else if (CODE_VALID_I && !pending_full) begin
      pending <= CODE_I;
      pending_full <= 1'b1;
    end else if (take) begin
      pending_full <= 1'b0;
    end
  end

  tbpd_latch u_latch (
    .CLK_I(CLK_I),
    .RESETN_I(RESETN_I),
    .load_i(take),
    .code_i(pending),
    .code_o(code)
  );

  always_comb begin
    next_state = state;
    case (state)
      tbpd_pkg::TBPD_IDLE: begin
        if (take) begin
          next_state = tbpd_pkg::TBPD_FUNC;
        end
      end
      tbpd_pkg::TBPD_FUNC: begin
        next_state = tbpd_pkg::TBPD_POS;
      end
      tbpd_pkg::TBPD_POS: begin
        next_state = tbpd_pkg::TBPD_LOCK;
      end
      tbpd_pkg::TBPD_LOCK: begin
        if (lock_cnt == LOCK_LAST) begin
          next_state = tbpd_pkg::TBPD_IDLE;
        end
      end
      default: begin
        next_state = tbpd_pkg::TBPD_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      state <= tbpd_pkg::TBPD_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      lock_cnt <= 2'h0;
    end else if (state == tbpd_pkg::TBPD_LOCK) begin
      lock_cnt <= lock_cnt + 2'h1;
    end else begin
      lock_cnt <= 2'h0;
    end
  end

  // common bar marks for either row bit; it alone settles the top row
  assign common_row = code[tbpd_pkg::BIT4] | code[tbpd_pkg::BIT5];

  always_comb begin
    if (!common_row) begin
      row = tbpd_pkg::ROW_TOP;
    end else if (code[tbpd_pkg::BIT5] && !code[tbpd_pkg::BIT4]) begin
      row = tbpd_pkg::ROW_SECOND;
    end else if (code[tbpd_pkg::BIT4] && !code[tbpd_pkg::BIT5]) begin
      row = tbpd_pkg::ROW_THIRD;
    end else begin
      row = tbpd_pkg::ROW_BOTTOM;
    end
  end

  // bit 1 marking alone is second column, bit 2 alone third
  assign col_in_group = {code[tbpd_pkg::BIT2], code[tbpd_pkg::BIT1]};
  // column = field half, then group (bit 3 marking is the left group), then column
  assign col = {field, !code[tbpd_pkg::BIT3], col_in_group};

  // field shifts during the function cycle only on a request for the other field
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      field <= tbpd_pkg::FIELD_RST;
    end else if (state == tbpd_pkg::TBPD_FUNC && code[tbpd_pkg::BIT7] != field) begin
      field <= code[tbpd_pkg::BIT7];
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      SHIFT_O <= 1'b0;
    end else begin
      SHIFT_O <= (state == tbpd_pkg::TBPD_FUNC) && (code[tbpd_pkg::BIT7] != field);
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      FUNC_START_O <= 1'b0;
      POS_START_O <= 1'b0;
      ROW_LOCK_O <= 1'b0;
    end else begin
      FUNC_START_O <= take;
      POS_START_O <= (state == tbpd_pkg::TBPD_FUNC);
      ROW_LOCK_O <= (next_state == tbpd_pkg::TBPD_LOCK);
    end
  end

  // registered result, valid from end of positioning until the next start
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      FIELD_O <= tbpd_pkg::FIELD_RST;
      ROW_O <= tbpd_pkg::ROW_TOP;
      COL_O <= 4'h0;
      POS_VALID_O <= 1'b0;
    end else if (state == tbpd_pkg::TBPD_POS) begin
      FIELD_O <= field;
      ROW_O <= row;
      COL_O <= col;
      POS_VALID_O <= 1'b1;
    end else if (take) begin
      POS_VALID_O <= 1'b0;
    end
  end
endmodule : tbpd_decoder
`default_nettype wire

// ==== pkg/tbpd_pkg.sv ====
// Overview of operation
// - every character resolves to a row and a column of a four by sixteen glyph matrix.
// - each glyph comes from one four by eight field, figures on the left half, letters right.
// - code bit 7 spacing picks the figures field and marking picks the letters field.
// - the field is stored state and shifts only when bit 7 asks for the other field.
// - the row index comes from code bits 4 and 5 alone.
// - code bit 3 picks the left or the right group of four columns inside the field.
// - code bits 1 and 2 pick one column of the group chosen by bit 3.
// - bits 5,4 give rows: both spacing top, 5 only second, 4 only third, both bottom.
// - a common row signal marks whenever bit 4 or bit 5 marks.
// - once the code is latched the function cycle starts before the positioning cycle.
// - positioning runs once per character and then returns to idle until retriggered.
// - the resolved row is held locked for a short time after the row search stops.
// - decoded bits stay latched while the next character is accepted at the input.
// - bits 2,1: both spacing first column, 1 only second, 2 only third, both fourth.
// - bit 3 marking places the glyph in the left half of the field, spacing the right.
`default_nettype none
package tbpd_pkg;
  localparam int CODE_W = 7;
  localparam int ROW_W = 2;
  localparam int COL_W = 4;
  localparam int BIT1 = 0;
  localparam int BIT2 = 1;
  localparam int BIT3 = 2;
  localparam int BIT4 = 3;
  localparam int BIT5 = 4;
  localparam int BIT7 = 6;
  localparam logic [6:0] CODE_RST = 7'h00;
  localparam logic FIELD_FIGS = 1'b0;
  localparam logic FIELD_LTRS = 1'b1;
  localparam logic FIELD_RST = FIELD_LTRS;
  localparam logic [1:0] ROW_TOP = 2'h0;
  localparam logic [1:0] ROW_SECOND = 2'h1;
  localparam logic [1:0] ROW_THIRD = 2'h2;
  localparam logic [1:0] ROW_BOTTOM = 2'h3;
  // lock time in ns and derived cycles at 10 MHz
  localparam int CLK_NS = 100;
  localparam int LOCK_NS = 200;
  localparam int LOCK_CYC = (LOCK_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [1:0] LOCK_CYC_W = 2'(LOCK_CYC);
  typedef enum logic [2:0] {
    TBPD_IDLE = 3'h0,
    TBPD_FUNC = 3'h1,
    TBPD_POS = 3'h3,
    TBPD_LOCK = 3'h2
  } tbpd_state_t;
endpackage : tbpd_pkg
`default_nettype wire

// ==== design/tbpd_latch.sv ====
`default_nettype none
// holds the decoded code set; a new set is only taken on load
module tbpd_latch (
  input wire logic CLK_I,
  input wire logic RESETN_I,
  input wire logic load_i,
  input wire logic [6:0] code_i,
  output logic [6:0] code_o
);
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      code_o <= tbpd_pkg::CODE_RST;
    end else if (load_i) begin
      code_o <= code_i;
    end
  end
endmodule : tbpd_latch
`default_nettype wire

// ==== tb/tbpd_decoder_asserts.sv ====
`default_nettype none
module tbpd_decoder_asserts (
  input wire logic CLK_I,
  input wire logic RESETN_I,
  input wire logic FUNC_START_O,
  input wire logic POS_START_O,
  input wire logic ROW_LOCK_O,
  input wire logic SHIFT_O,
  input wire logic FIELD_O,
  input wire logic [3:0] COL_O,
  input wire logic POS_VALID_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RESETN_I);
  a_func_then_pos: assert property (FUNC_START_O |=> POS_START_O) else $error("late pos");
  a_pos_once: assert property (POS_START_O |=> !POS_START_O [*3]) else $error("pos twice");
  a_lock_two: assert property ($rose(ROW_LOCK_O) |=> ROW_LOCK_O ##1 !ROW_LOCK_O)
    else $error("lock length");
  a_lock_at_pos: assert property (POS_START_O |=> $rose(ROW_LOCK_O)) else $error("no lock");
  a_pos_valid: assert property (POS_START_O |=> POS_VALID_O) else $error("no valid");
  a_col_field: assert property (POS_VALID_O |-> COL_O[3] == FIELD_O) else $error("half");
  a_shift_flips: assert property (SHIFT_O |=> FIELD_O != $past(FIELD_O))
    else $error("no flip");
  a_keep_field: assert property (POS_START_O && !SHIFT_O |=> $stable(FIELD_O))
    else $error("field moved");
endmodule : tbpd_decoder_asserts
bind tbpd_decoder tbpd_decoder_asserts tbpd_decoder_asserts_inst (.CLK_I(CLK_I),
  .RESETN_I(RESETN_I), .FUNC_START_O(FUNC_START_O), .POS_START_O(POS_START_O),
  .ROW_LOCK_O(ROW_LOCK_O), .SHIFT_O(SHIFT_O), .FIELD_O(FIELD_O), .COL_O(COL_O),
  .POS_VALID_O(POS_VALID_O));
`default_nettype wire

// ==== tb/tbpd_selector.sv ====
`default_nettype none
module tbpd_selector (
  input wire logic clk_i,
  input wire logic ready_i,
  output logic valid_o,
  output logic [6:0] code_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    valid_o = 1'b0;
    code_o = 7'h55;
  end
  // idle code is inverted so a stale set never looks valid
  task automatic send(input logic [6:0] c);
    @(negedge clk_i);
    valid_o = 1'b1;
    code_o = c;
    do @(posedge clk_i); while (ready_i !== 1'b1);
    @(negedge clk_i);
    valid_o = 1'b0;
    code_o = ~c;
  endtask : send
endmodule : tbpd_selector
`default_nettype wire

// ==== tb/tbpd_decoder_tb_top.sv ====
`default_nettype none
module tbpd_decoder_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  `define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin miscompares++; \
    $display("wrong value %s exp %h got %h", n, e, a); end end
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic valid, ready, func_st, pos_st, lock, shift, field, pos_valid;
  logic [6:0] code;
  logic [1:0] row;
  logic [3:0] col;
  logic fld = 1'b1;
  int seed = 54;
  int miscompares = 0;
  int total_checks = 0;
  logic [6:0] corner [8] = '{7'h00, 7'h00, 7'h7f, 7'h10, 7'h08, 7'h01, 7'h02, 7'h44};
  always #50 clk = ~clk;
  tbpd_selector tbpd_selector_inst (.clk_i(clk), .ready_i(ready), .valid_o(valid), .code_o(code));
  tbpd_decoder tbpd_decoder_inst (.CLK_I(clk), .RESETN_I(rst_n), .CODE_VALID_I(valid),
    .CODE_I(code), .READY_O(ready), .FUNC_START_O(func_st), .POS_START_O(pos_st),
    .ROW_LOCK_O(lock), .SHIFT_O(shift), .FIELD_O(field), .ROW_O(row), .COL_O(col),
    .POS_VALID_O(pos_valid));
  function automatic logic [7:0] expect_pos(input logic [6:0] c);
    return {1'b1, c[6], c[3], c[4], c[6], ~c[2], c[1], c[0]};
  endfunction : expect_pos
  task automatic run_char(input logic [6:0] c);
    int n;
    n = 0;
    tbpd_selector_inst.send(c);
    while (pos_st !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    `CHK("shift", c[6] ^ fld, shift)
    fld = c[6];
    @(negedge clk);
    `CHK("position", expect_pos(c), {pos_valid, field, row, col})
  endtask : run_char
  task automatic conclude();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude
  initial begin
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    `CHK("reset", 3'b101, {field, pos_valid, ready})
    foreach (corner[i]) run_char(corner[i]);
    // reset in mid-run while the row lock is still held
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    fld = 1'b1;
    `CHK("reset again", 3'b101, {field, pos_valid, ready})
    repeat (40) run_char(7'($random(seed)));
    conclude();
  end
  initial begin
    #200000;
    miscompares++;
    conclude();
  end
endmodule : tbpd_decoder_tb_top
`default_nettype wire
